// ### logic/dgc_consts.vh
// constants for the gain calibration control block
`ifndef DGC_CONSTS_VH
`define DGC_CONSTS_VH

// ----------------------------------------------------------------
// register word addresses on the serial port
// ----------------------------------------------------------------
`define DGC_ADDR_SPI_CFG 15'h0000
`define DGC_ADDR_REF_TRIM 15'h0003
`define DGC_ADDR_RANGE_SEL 15'h0008
`define DGC_ADDR_RES_SEL 15'h000a
`define DGC_ADDR_RES_SET 15'h000b
`define DGC_ADDR_GAIN_SET 15'h000c
`define DGC_ADDR_CAL_CTRL 15'h000d
`define DGC_ADDR_CAL_START 15'h000e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DGC_SPI_CFG_RESET 0
`define DGC_CTRL_CLK_EN 3
`define DGC_CTRL_MODE_EN 6
`define DGC_CTRL_CAL_RST 7
`define DGC_CTRL_BUSY 15
`define DGC_START_BIT 0
`define DGC_DONE_BIT 1
`define DGC_RES_SEL_BIT 15
`define DGC_FLAG_REFUSED 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DGC_RST_DIV 3'h7
`define DGC_RST_TRIM 6'h00
`define DGC_RST_RANGE 8'h00
`define DGC_RST_RANGE_HI 2'h0
`define DGC_RST_RES 5'h00
`define DGC_RST_GAIN 6'h00

// ----------------------------------------------------------------
// timing: calibration cycle is base shifted by divider field
// ----------------------------------------------------------------
`define DGC_DIV_BASE 10'h004
`define DGC_CMP_TOP 3'h3
`define DGC_RES_TOP 3'h4
`define DGC_GAIN_TOP 3'h5

`endif

// ### logic/dgc_spi_slave.v
// serial port slave giving word access to the register file
`timescale 1ns/100ps
`include "dgc_consts.vh"
module dgc_spi_slave (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // serial pins, sampled on the system clock
  input wire i_spi_cs_b,
  input wire i_spi_sclk,
  input wire i_spi_sdi,
  output wire o_spi_sdo,
  output wire o_spi_sdo_oe,
  // register side
  output reg [14:0] o_addr,
  output reg [15:0] o_wdata,
  output reg o_wr_stb,
  input wire [15:0] i_rdata
);

reg sclk_q;
reg [3:0] bit_cnt;
reg [15:0] rx;
reg [15:0] tx;
reg cmd_phase;
reg is_read;
reg tx_armed;
wire rise = i_spi_sclk & ~sclk_q;
wire fall = ~i_spi_sclk & sclk_q;
wire [15:0] next_rx = {rx[14:0], i_spi_sdi};
wire word_end = rise & (bit_cnt == 4'hf);

assign o_spi_sdo = tx[15];
assign o_spi_sdo_oe = ~i_spi_cs_b & is_read & ~cmd_phase;

// ----------------------------------------------------------------
// frame: command word, then data words with address increment
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_b) begin
  if (!i_rst_b) begin
    sclk_q <= 1'b0;
    bit_cnt <= 4'h0;
    rx <= 16'h0000;
    tx <= 16'h0000;
    cmd_phase <= 1'b1;
    is_read <= 1'b0;
    tx_armed <= 1'b0;
    o_addr <= 15'h0000;
    o_wdata <= 16'h0000;
    o_wr_stb <= 1'b0;
  end else begin
    sclk_q <= i_spi_sclk;
    o_wr_stb <= 1'b0;
    if (i_spi_cs_b) begin
      bit_cnt <= 4'h0;
      cmd_phase <= 1'b1;
      is_read <= 1'b0;
    end else begin
      if (rise) begin
        rx <= next_rx;
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (word_end && cmd_phase) begin
        cmd_phase <= 1'b0;
        is_read <= next_rx[15];
        o_addr <= next_rx[14:0];
      end else if (word_end && is_read) begin
        o_addr <= o_addr + 15'h0001;
      end else if (word_end) begin
        o_wdata <= next_rx;
        o_wr_stb <= 1'b1;
      end
      // a write moves the address only after its strobe has been used
      if (o_wr_stb) begin
        o_addr <= o_addr + 15'h0001;
      end
      // read data loads after each word; sdo moves on falling edges
      if (word_end && (cmd_phase ? next_rx[15] : is_read)) begin
        tx <= cmd_phase ? 16'h0000 : 16'h0000;
        tx_armed <= 1'b0;
      end else if (fall && tx_armed) begin
        tx <= {tx[14:0], 1'b0};
      end else if (fall) begin
        tx_armed <= 1'b1;
      end
      // one cycle after word end the address points at the next word
      if (!tx_armed && !rise && !fall && is_read && !cmd_phase &&
          bit_cnt == 4'h0) begin
        tx <= i_rdata;
      end
    end
  end
end

endmodule // dgc_spi_slave

// ### logic/dgc_gain_cal.v
// gain calibration control: registers, reference trim, sequencer
// Operation
// - calibration runs only with the on-chip gain resistor selected
// - calibration tick comes from sample clock divided by divider field
// - a calibration cycle lasts 4 to 512 clocks, default 512
// - start runs comparator, then resistor, then gain calibration
// - busy flag high while calibrating, done flag set at completion
// - range overflow and underflow flags in control bits 13:8, refused start flag in bit 14
// - resistor and gain results readable for software to copy
// - mode enable steers resistor and gain muxes to calibration values
// - calibration reset bit pulse, reset pin or port reset clear state
// - select bit 15 picks on-chip resistor, bits 4:0 set its value
// - six-bit trim adjusts internal reference level
// - reference powered and usable straight out of reset
// - serial port writes all configuration registers and reads back all of them except the port configuration word
`timescale 1ns/100ps
`include "dgc_consts.vh"
module dgc_gain_cal (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // serial port
  input wire i_spi_cs_b,
  input wire i_spi_sclk,
  input wire i_spi_sdi,
  output wire o_spi_sdo,
  output wire o_spi_sdo_oe,
  // analog calibration comparator, high when trial is too large
  input wire i_cmp_high,
  // analog controls
  output reg o_ref_power_up,
  output reg [5:0] o_ref_trim_code,
  output reg o_use_onchip_res,
  output reg [4:0] o_resistor_code,
  output reg [5:0] o_gain_code,
  output reg [3:0] o_cmp_trim,
  output reg [9:0] o_cal_ranges,
  output reg o_cal_active
);

localparam ST_IDLE = 4'h1;
localparam ST_CMP = 4'h2;
localparam ST_RES = 4'h4;
localparam ST_GAIN = 4'h8;

wire [14:0] addr;
wire [15:0] wdata;
wire wr_stb;
reg [15:0] rdata;

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg [5:0] reference_trim_code;
reg [7:0] range_sel;
reg [2:0] cal_div;
reg cal_clk_en;
reg [1:0] range_hi;
reg cal_mode_en;
reg cal_rst_bit;
reg start_cal;
reg calibration_done_flag;
reg res_sel;
reg [4:0] resistor_setting;
reg [5:0] gain_setting;
reg [4:0] resistor_result;
reg [5:0] gain_result;
reg [3:0] cmp_result;
reg [6:0] range_flags;
reg [3:0] state;
reg [5:0] trial;
reg [2:0] bitp;
reg [9:0] div_cnt;
reg soft_rst;

wire busy = ~state[0];
wire wr_cfg = wr_stb & (addr == `DGC_ADDR_SPI_CFG);
wire wr_ctrl = wr_stb & (addr == `DGC_ADDR_CAL_CTRL);
wire wr_start = wr_stb & (addr == `DGC_ADDR_CAL_START);
// calibration reset acts on the one-then-zero pulse of its bit
wire cal_clear = soft_rst |
  (wr_ctrl & cal_rst_bit & ~wdata[`DGC_CTRL_CAL_RST]);
wire [9:0] div_last = (`DGC_DIV_BASE << cal_div) - 10'h001;
wire tick = cal_clk_en & (div_cnt == div_last);
wire cal_ok = cal_mode_en & res_sel;
wire [5:0] bit_mask = 6'h01 << bitp;
wire [5:0] kept = i_cmp_high ? (trial & ~bit_mask) : trial;
wire last_bit = (bitp == 3'h0);

dgc_spi_slave u_spi (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_spi_cs_b(i_spi_cs_b),
  .i_spi_sclk(i_spi_sclk),
  .i_spi_sdi(i_spi_sdi),
  .o_spi_sdo(o_spi_sdo),
  .o_spi_sdo_oe(o_spi_sdo_oe),
  .o_addr(addr),
  .o_wdata(wdata),
  .o_wr_stb(wr_stb),
  .i_rdata(rdata)
);

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_b) begin
  if (!i_rst_b) begin
    soft_rst <= 1'b0;
    reference_trim_code <= `DGC_RST_TRIM;
    range_sel <= `DGC_RST_RANGE;
    cal_div <= `DGC_RST_DIV;
    cal_clk_en <= 1'b0;
    range_hi <= `DGC_RST_RANGE_HI;
    cal_mode_en <= 1'b0;
    cal_rst_bit <= 1'b0;
    start_cal <= 1'b0;
    res_sel <= 1'b0;
    resistor_setting <= `DGC_RST_RES;
    gain_setting <= `DGC_RST_GAIN;
  end else if (soft_rst) begin
    // port reset bit clears itself together with the register file
    soft_rst <= 1'b0;
    reference_trim_code <= `DGC_RST_TRIM;
    range_sel <= `DGC_RST_RANGE;
    cal_div <= `DGC_RST_DIV;
    cal_clk_en <= 1'b0;
    range_hi <= `DGC_RST_RANGE_HI;
    cal_mode_en <= 1'b0;
    cal_rst_bit <= 1'b0;
    start_cal <= 1'b0;
    res_sel <= 1'b0;
    resistor_setting <= `DGC_RST_RES;
    gain_setting <= `DGC_RST_GAIN;
  end else if (wr_stb) begin
    case (addr)
      `DGC_ADDR_SPI_CFG: begin
        soft_rst <= wdata[`DGC_SPI_CFG_RESET];
      end
      `DGC_ADDR_REF_TRIM: begin
        reference_trim_code <= wdata[5:0];
      end
      `DGC_ADDR_RANGE_SEL: begin
        range_sel <= wdata[7:0];
      end
      `DGC_ADDR_RES_SEL: begin
        res_sel <= wdata[`DGC_RES_SEL_BIT];
        resistor_setting <= wdata[4:0];
      end
      `DGC_ADDR_RES_SET: begin
        resistor_setting <= wdata[4:0];
      end
      `DGC_ADDR_GAIN_SET: begin
        gain_setting <= wdata[5:0];
      end
      `DGC_ADDR_CAL_CTRL: begin
        cal_div <= wdata[2:0];
        cal_clk_en <= wdata[`DGC_CTRL_CLK_EN];
        range_hi <= wdata[5:4];
        cal_mode_en <= wdata[`DGC_CTRL_MODE_EN];
        cal_rst_bit <= wdata[`DGC_CTRL_CAL_RST];
      end
      `DGC_ADDR_CAL_START: begin
        start_cal <= wdata[`DGC_START_BIT];
      end
      default: begin
        start_cal <= start_cal;
      end
    endcase
  end
end

// ----------------------------------------------------------------
// calibration tick divider
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_b) begin
  if (!i_rst_b) begin
    div_cnt <= 10'h000;
  end else if (!cal_clk_en || tick) begin
    div_cnt <= 10'h000;
  end else begin
    div_cnt <= div_cnt + 10'h001;
  end
end

// ----------------------------------------------------------------
// sequencer: successive approximation per phase, one bit per tick
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_b) begin
  if (!i_rst_b) begin
    state <= ST_IDLE;
    trial <= 6'h00;
    bitp <= 3'h0;
    cmp_result <= 4'h0;
    resistor_result <= 5'h00;
    gain_result <= 6'h00;
    range_flags <= 7'h00;
    calibration_done_flag <= 1'b0;
  end else if (cal_clear) begin
    state <= ST_IDLE;
    trial <= 6'h00;
    bitp <= 3'h0;
    cmp_result <= 4'h0;
    resistor_result <= 5'h00;
    gain_result <= 6'h00;
    range_flags <= 7'h00;
    calibration_done_flag <= 1'b0;
  end else begin
    // zero written to start clears done; completion in that cycle wins
    if (wr_start && !wdata[`DGC_START_BIT]) begin
      calibration_done_flag <= 1'b0;
    end
    if (wr_start && wdata[`DGC_START_BIT] && !cal_ok) begin
      range_flags[`DGC_FLAG_REFUSED] <= 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (start_cal && cal_ok && !calibration_done_flag && tick) begin
          state <= ST_CMP;
          range_flags <= 7'h00;
          bitp <= `DGC_CMP_TOP;
          trial <= 6'h01 << `DGC_CMP_TOP;
        end
      end
      ST_CMP: begin
        if (tick && last_bit) begin
          cmp_result <= kept[3:0];
          range_flags[0] <= (kept[3:0] == 4'h0);
          range_flags[1] <= (kept[3:0] == 4'hf);
          state <= ST_RES;
          bitp <= `DGC_RES_TOP;
          trial <= 6'h01 << `DGC_RES_TOP;
        end else if (tick) begin
          trial <= kept | (bit_mask >> 1);
          bitp <= bitp - 3'h1;
        end
      end
      ST_RES: begin
        if (tick && last_bit) begin
          resistor_result <= kept[4:0];
          range_flags[2] <= (kept[4:0] == 5'h00);
          range_flags[3] <= (kept[4:0] == 5'h1f);
          state <= ST_GAIN;
          bitp <= `DGC_GAIN_TOP;
          trial <= 6'h01 << `DGC_GAIN_TOP;
        end else if (tick) begin
          trial <= kept | (bit_mask >> 1);
          bitp <= bitp - 3'h1;
        end
      end
      ST_GAIN: begin
        if (tick && last_bit) begin
          gain_result <= kept;
          range_flags[4] <= (kept == 6'h00);
          range_flags[5] <= (kept == 6'h3f);
          state <= ST_IDLE;
          calibration_done_flag <= 1'b1;
        end else if (tick) begin
          trial <= kept | (bit_mask >> 1);
          bitp <= bitp - 3'h1;
        end
      end
      default: begin
        state <= ST_IDLE;
      end
    endcase
  end
end

// ----------------------------------------------------------------
// readback
// ----------------------------------------------------------------
always @* begin
  rdata = 16'h0000;
  case (addr)
    `DGC_ADDR_REF_TRIM: rdata = {10'h000, reference_trim_code};
    `DGC_ADDR_RANGE_SEL: rdata = {8'h00, range_sel};
    `DGC_ADDR_RES_SEL: rdata = {res_sel, 10'h000, resistor_setting};
    `DGC_ADDR_RES_SET:
      rdata = {3'h0, resistor_result, 3'h0, resistor_setting};
    `DGC_ADDR_GAIN_SET: rdata = {2'h0, gain_result, 2'h0, gain_setting};
    `DGC_ADDR_CAL_CTRL:
      rdata = {busy, range_flags, cal_rst_bit, cal_mode_en, range_hi,
        cal_clk_en, cal_div};
    `DGC_ADDR_CAL_START:
      rdata = {14'h0000, calibration_done_flag, start_cal};
    default: rdata = 16'h0000;
  endcase
end

// ----------------------------------------------------------------
// analog control outputs, registered to keep them glitch free
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_b) begin
  if (!i_rst_b) begin
    o_ref_power_up <= 1'b1;
    o_ref_trim_code <= `DGC_RST_TRIM;
    o_use_onchip_res <= 1'b0;
    o_resistor_code <= `DGC_RST_RES;
    o_gain_code <= `DGC_RST_GAIN;
    o_cmp_trim <= 4'h0;
    o_cal_ranges <= 10'h000;
    o_cal_active <= 1'b0;
  end else begin
    o_ref_power_up <= 1'b1;
    o_ref_trim_code <= reference_trim_code;
    o_use_onchip_res <= res_sel;
    o_cal_ranges <= {range_hi, range_sel};
    o_cal_active <= busy;
    o_cmp_trim <= state[1] ? trial[3:0] : cmp_result;
    if (cal_mode_en) begin
      o_resistor_code <= state[2] ? trial[4:0] : resistor_result;
      o_gain_code <= state[3] ? trial : gain_result;
    end else begin
      o_resistor_code <= resistor_setting;
      o_gain_code <= gain_setting;
    end
  end
end

endmodule // dgc_gain_cal

// ### verif/dgc_gain_cal_assertions.sv
// assertion checker for the gain calibration control block
`timescale 1ns/100ps
module dgc_gain_cal_chk (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // observed ports
  input wire i_spi_cs_b,
  input wire o_spi_sdo_oe,
  input wire o_ref_power_up,
  input wire [5:0] o_ref_trim_code,
  input wire o_use_onchip_res,
  input wire [4:0] o_resistor_code,
  input wire [5:0] o_gain_code,
  input wire [9:0] o_cal_ranges,
  input wire o_cal_active
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // registers may still settle a few clocks after a frame ends
  reg [4:0] idle_cnt;
  reg [13:0] busy_cnt;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_cnt <= 5'h00;
      busy_cnt <= 14'h0000;
    end else begin
      if (!i_spi_cs_b)
        idle_cnt <= 5'h00;
      else if (idle_cnt != 5'h1f)
        idle_cnt <= idle_cnt + 5'h01;
      if (!o_cal_active)
        busy_cnt <= 14'h0000;
      else if (busy_cnt != 14'h3fff)
        busy_cnt <= busy_cnt + 14'h0001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_busy_hold;
    o_cal_active [*8];
  endsequence
  sequence s_oe_quiet;
    !o_spi_sdo_oe [*8];
  endsequence
  AST_REF_ON: assert property (o_ref_power_up)
    else $error("reference not powered");
  AST_OE_CS: assert property (o_spi_sdo_oe |-> !i_spi_cs_b)
    else $error("data out driven without select");
  AST_OE_CMD: assert property ($fell(i_spi_cs_b) |-> s_oe_quiet)
    else $error("data out driven during command");
  AST_BUSY_RES: assert property ($rose(o_cal_active) |-> o_use_onchip_res)
    else $error("calibration without on-chip resistor");
  AST_BUSY_MIN: assert property ($rose(o_cal_active) |-> s_busy_hold)
    else $error("calibration too short");
  AST_BUSY_MAX: assert property (busy_cnt < 14'h2010)
    else $error("calibration too long");
  AST_CFG_STILL: assert property (idle_cnt > 5'h08 |->
    $stable(o_ref_trim_code) && $stable(o_cal_ranges)
    && $stable(o_use_onchip_res))
    else $error("setting changed without access");
  AST_CAL_STILL: assert property (idle_cnt > 5'h08 && !o_cal_active
    && !$past(o_cal_active) && !$past(o_cal_active, 2)
    |-> $stable(o_resistor_code) && $stable(o_gain_code))
    else $error("code changed while idle");
endmodule // dgc_gain_cal_chk

bind dgc_gain_cal dgc_gain_cal_chk u_dgc_gain_cal_chk (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_spi_cs_b(i_spi_cs_b),
  .o_spi_sdo_oe(o_spi_sdo_oe),
  .o_ref_power_up(o_ref_power_up),
  .o_ref_trim_code(o_ref_trim_code),
  .o_use_onchip_res(o_use_onchip_res),
  .o_resistor_code(o_resistor_code),
  .o_gain_code(o_gain_code),
  .o_cal_ranges(o_cal_ranges),
  .o_cal_active(o_cal_active)
);

// ### verif/test_dgc_gain_cal.sv
// testbench for the gain calibration control block
`timescale 1ns/100ps
`include "dgc_consts.vh"
module test_dgc_gain_cal;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_spi_cs_b = 1'b1;
  logic i_spi_sclk = 1'b0;
  logic i_spi_sdi = 1'b0;
  logic i_cmp_high = 1'b0;
  wire o_spi_sdo, o_spi_sdo_oe, o_ref_power_up, o_use_onchip_res;
  wire o_cal_active;
  wire [5:0] o_ref_trim_code, o_gain_code;
  wire [4:0] o_resistor_code;
  wire [3:0] o_cmp_trim;
  wire [9:0] o_cal_ranges;
  integer n_fail = 0;
  integer checked = 0;
  integer bcnt = 0;
  logic [15:0] v;
  dgc_gain_cal u_dgc_gain_cal (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_spi_cs_b(i_spi_cs_b),
    .i_spi_sclk(i_spi_sclk), .i_spi_sdi(i_spi_sdi),
    .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe),
    .i_cmp_high(i_cmp_high), .o_ref_power_up(o_ref_power_up),
    .o_ref_trim_code(o_ref_trim_code),
    .o_use_onchip_res(o_use_onchip_res),
    .o_resistor_code(o_resistor_code), .o_gain_code(o_gain_code),
    .o_cmp_trim(o_cmp_trim), .o_cal_ranges(o_cal_ranges),
    .o_cal_active(o_cal_active)
  );
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_cal_active === 1'b1)
      bcnt <= bcnt + 1;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    begin
      checked = checked + 1;
      if (seen !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
    end
  endtask
  // sclk held low two clocks and high three, so it stays slow for the sampler
  task spi(input logic rw, input logic [14:0] a, input logic [15:0] wd);
    logic [31:0] sh;
    integer k;
    begin
      sh = {rw, a, wd};
      @(negedge i_clk) i_spi_cs_b = 1'b0;
      for (k = 31; k >= 0; k = k - 1) begin
        @(negedge i_clk) i_spi_sclk = 1'b0;
        i_spi_sdi = sh[k];
        repeat (2) @(negedge i_clk);
        i_spi_sclk = 1'b1;
        if (k < 16)
          v[k] = o_spi_sdo;
        repeat (2) @(negedge i_clk);
      end
      repeat (3) @(negedge i_clk);
      i_spi_sclk = 1'b0;
      i_spi_cs_b = 1'b1;
      repeat (3) @(negedge i_clk);
    end
  endtask
  task wr(input logic [14:0] a, input logic [15:0] d);
    spi(1'b0, a, d);
  endtask
  task rd(input logic [14:0] a, input logic [15:0] m, input logic [15:0] e,
          input string nm);
    begin
      spi(1'b1, a, 16'h0000);
      chk(nm, v & m, e);
    end
  endtask
  task run(input logic [2:0] dv, input logic cmp, input logic [4:0] r,
           input logic [5:0] g);
    integer k;
    integer p;
    logic [15:0] fl;
    begin
      p = 4 << dv;
      i_cmp_high = cmp;
      wr(`DGC_ADDR_CAL_CTRL, 16'h0048 | {13'h0000, dv});
      bcnt = 0;
      wr(`DGC_ADDR_CAL_START, 16'h0001);
      for (k = 0; k < 9000 && !(bcnt > 0 && o_cal_active === 1'b0);
           k = k + 1)
        @(negedge i_clk);
      if (k == 9000) begin
        n_fail = n_fail + 1;
        summarize;
      end
      chk("busy length", {15'h0000, bcnt > 14*p && bcnt <= 16*p}, 16'h0001);
      rd(`DGC_ADDR_CAL_START, 16'hffff, 16'h0003, "done flag");
      chk("res mux", {11'h000, o_resistor_code}, {11'h000, r});
      chk("gain mux", {10'h000, o_gain_code}, {10'h000, g});
      fl = cmp ? 16'h0000 : 16'h000f;
      chk("cmp trim", {12'h000, o_cmp_trim}, fl);
      fl = cmp ? 16'h1500 : 16'h2a00;
      rd(`DGC_ADDR_CAL_CTRL, 16'hff00, fl, "range flags");
      rd(`DGC_ADDR_RES_SET, 16'h1f00, {3'h0, r, 8'h00}, "res result");
      rd(`DGC_ADDR_GAIN_SET, 16'h3f00, {2'h0, g, 8'h00}, "gain result");
      wr(`DGC_ADDR_CAL_START, 16'h0000);
      rd(`DGC_ADDR_CAL_START, 16'hffff, 16'h0000, "done clear");
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("ref power", {15'h0000, o_ref_power_up}, 16'h0001);
    rd(`DGC_ADDR_CAL_CTRL, 16'hffff, 16'h0007, "ctrl reset");
    wr(`DGC_ADDR_REF_TRIM, 16'h0015);
    chk("trim out", {10'h000, o_ref_trim_code}, 16'h0015);
    rd(`DGC_ADDR_REF_TRIM, 16'hffff, 16'h0015, "trim reg");
    rd(15'h0005, 16'hffff, 16'h0000, "unmapped");
    wr(`DGC_ADDR_RANGE_SEL, 16'h005a);
    wr(`DGC_ADDR_CAL_CTRL, 16'h0027);
    chk("ranges", {6'h00, o_cal_ranges}, 16'h025a);
    wr(`DGC_ADDR_RANGE_SEL, 16'h0000);
    // start with the board resistor still selected must be refused
    wr(`DGC_ADDR_CAL_CTRL, 16'h0048);
    wr(`DGC_ADDR_CAL_START, 16'h0001);
    repeat (40) @(negedge i_clk);
    chk("no run", {15'h0000, o_cal_active}, 16'h0000);
    rd(`DGC_ADDR_CAL_CTRL, 16'h4000, 16'h4000, "refused flag");
    wr(`DGC_ADDR_CAL_START, 16'h0000);
    wr(`DGC_ADDR_RES_SEL, 16'h8005);
    wr(`DGC_ADDR_GAIN_SET, 16'h0009);
    chk("onchip res", {15'h0000, o_use_onchip_res}, 16'h0001);
    rd(`DGC_ADDR_RES_SET, 16'h001f, 16'h0005, "res setting");
    run(3'h1, 1'b1, 5'h00, 6'h00);
    run(3'h0, 1'b0, 5'h1f, 6'h3f);
    // default divider keeps the calibration clock slow enough
    run(3'h7, 1'b1, 5'h00, 6'h00);
    wr(`DGC_ADDR_CAL_CTRL, 16'h0008);
    chk("res regular", {11'h000, o_resistor_code}, 16'h0005);
    chk("gain regular", {10'h000, o_gain_code}, 16'h0009);
    wr(`DGC_ADDR_CAL_CTRL, 16'h0080);
    wr(`DGC_ADDR_CAL_CTRL, 16'h0000);
    rd(`DGC_ADDR_RES_SET, 16'h1f00, 16'h0000, "cal reset");
    wr(`DGC_ADDR_SPI_CFG, 16'h0001);
    rd(`DGC_ADDR_REF_TRIM, 16'hffff, 16'h0000, "port reset");
    rd(`DGC_ADDR_CAL_CTRL, 16'hffff, 16'h0007, "ctrl after");
    chk("trim after", {10'h000, o_ref_trim_code}, 16'h0000);
    // reset pin pulsed while a calibration is running
    wr(`DGC_ADDR_RES_SEL, 16'h8000);
    wr(`DGC_ADDR_CAL_CTRL, 16'h0048);
    wr(`DGC_ADDR_CAL_START, 16'h0001);
    repeat (20) @(negedge i_clk);
    chk("mid run", {15'h0000, o_cal_active}, 16'h0001);
    i_rst_b = 1'b0;
    repeat (5) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("pin reset", {15'h0000, o_cal_active}, 16'h0000);
    rd(`DGC_ADDR_CAL_START, 16'hffff, 16'h0000, "start after pin");
    rd(`DGC_ADDR_CAL_CTRL, 16'hffff, 16'h0007, "ctrl after pin");
    summarize;
  end
endmodule // test_dgc_gain_cal
